// ==== hdl/mbist_da_defines.svh ====
`ifndef MBIST_DA_DEFINES_SVH
`define MBIST_DA_DEFINES_SVH

// Register byte offsets on the plain register port.
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_IRQ_STAT   8'h08
`define REG_IRQ_MASK   8'h0c
`define REG_PASS_CNT   8'h10
`define REG_FAIL_MAP   8'h14

// Control register fields.
`define CTRL_SINGLE    0
`define CTRL_LOOP      1
`define CTRL_DEV_SER   2
`define CTRL_ENG_SER   3
`define CTRL_W         4
`define CTRL_RST       4'h0

// Status register fields.
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 4
`define STAT_MODE      5
`define STAT_RESULT    6

// Interrupt status and mask fields.
`define IRQ_DONE       0
`define IRQ_FAIL       1
`define IRQ_LOOP       2
`define IRQ_W          3
`define IRQ_RST        3'h0

// Pass counter.
`define PASS_W         16
`define PASS_RST       16'h0000

// Self-test clock periods a run input must stay inactive before it counts.
`define QUAL_INACTIVE_CYC 3

// Default period of an external self-test clock, in picoseconds.
`define EXT_TEST_CLK_PERIOD_PS 50000

`endif

// ==== hdl/mbist_da_pkg.sv ====
package mbist_da_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_LAUNCH = 5'h02,
      ST_WAIT   = 5'h04,
      ST_NEXT   = 5'h08,
      ST_HOLD   = 5'h10
   } seq_state_type;

   // Run mode latched when a test sequence starts.
   typedef enum logic {
      MODE_SINGLE = 1'h0,
      MODE_LOOP   = 1'h1
   } run_mode_type;

endpackage

// ==== hdl/level_sync.sv ====
`timescale 1ns/1ns
module level_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  logic         sys_clk,
   input  logic         rst,
   // Levels from outside and their synchronised copies.
   input  logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // The first stage feeds only the second one, never any logic.
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Two flip-flops per level; constants only under reset.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

   AST_SYNC_TWO_STAGE: assert property (
      @(posedge sys_clk) disable iff (rst)
      $past(!rst, 2) |-> sync_out == $past(async_in, 2))
      else $error("synchroniser output is not two cycles behind");

endmodule

// ==== hdl/run_qualifier.sv ====
`timescale 1ns/1ns
`include "mbist_da_defines.svh"
module run_qualifier #(
   parameter int QUAL = `QUAL_INACTIVE_CYC
) (
   // Clock and reset.
   input  logic sys_clk,
   input  logic rst,
   // Active-high run level and the qualified run level.
   input  logic level_in,
   output logic run_ok
);

   localparam int QW = $clog2(QUAL + 1);

   logic [QW-1:0] idle_cnt_q;
   logic [QW-1:0] idle_cnt_d;
   logic          armed_q;
   logic          armed_d;

   // Count inactive cycles; a run counts only after enough of them, so a
   // level that was already high when the sequence began is ignored.
   always_comb begin
      idle_cnt_d = idle_cnt_q;
      armed_d    = armed_q;
      if (!level_in) begin
         armed_d = 1'h0;
         if (idle_cnt_q != QW'(QUAL)) begin
            idle_cnt_d = idle_cnt_q + QW'(1);
         end
      end else begin
         if (idle_cnt_q == QW'(QUAL)) begin
            armed_d = 1'h1;
         end
         if (!armed_q) begin
            idle_cnt_d = '0;
         end
      end
   end

   // Register the qualifier state.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idle_cnt_q <= '0;
         armed_q    <= 1'h0;
      end else begin
         idle_cnt_q <= idle_cnt_d;
         armed_q    <= armed_d;
      end
   end

   assign run_ok = armed_q;

   AST_QUAL_INACTIVE_GAP: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(run_ok) |-> $past(level_in, 1) && !$past(level_in, 2) &&
                        !$past(level_in, 3) && !$past(level_in, 4))
      else $error("run accepted without three inactive cycles");

endmodule

// ==== hdl/mbist_direct_access_ctrl.sv ====
// Functional notes
// - Every direct access input and the monitor output act as levels; with INTERNAL_CLK set, the schedule steps on edges of tt_ctrl.
// - Each direct access signal has its own active polarity parameter.
// - Register control works beside the pins, or alone in place of them.
// - While the loop input is active the test repeats; it stops on release.
// - Device serial select runs the devices of each controller in turn.
// - Controller serial select runs the controllers in turn.
// - In a single pass the monitor is AND of all done and all not-fail.
// - In a loop the monitor is AND of all not-fail, done excluded.
// - The monitor path is dedicated and never gated by an enable.
// - Repair logic runs on the same clock that runs the memory test.
// - A qualified single run executes once and shows its result at end.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "mbist_da_defines.svh"
module mbist_direct_access_ctrl #(
   parameter int   N_CTRL       = 2,
   parameter int   N_DEV        = 4,
   parameter logic ACT_SINGLE   = 1'h1,
   parameter logic ACT_LOOP     = 1'h1,
   parameter logic ACT_DEV_SER  = 1'h1,
   parameter logic ACT_ENG_SER  = 1'h1,
   parameter logic ACT_MONITOR  = 1'h1,
   parameter logic INTERNAL_CLK = 1'h0
) (
   // Clock and reset.
   input  logic                        sys_clk,
   input  logic                        rst,
   // Direct access pins.
   input  logic                        da_single_run,
   input  logic                        da_loop_run,
   input  logic                        da_dev_serial,
   input  logic                        da_eng_serial,
   input  logic                        tt_ctrl,
   output logic                        da_monitor,
   // Self-test devices, controller-major order.
   output logic [N_CTRL*N_DEV-1:0]     dev_start,
   input  logic [N_CTRL*N_DEV-1:0]     dev_done,
   input  logic [N_CTRL*N_DEV-1:0]     dev_fail,
   output logic [N_CTRL*N_DEV-1:0]     dev_repair_en,
   // Register port.
   input  logic [7:0]                  reg_addr,
   input  logic [31:0]                 reg_wdata,
   input  logic                        reg_wr,
   input  logic                        reg_rd,
   output logic [31:0]                 reg_rdata,
   // Interrupt and state view.
   output logic                        irq,
   output mbist_da_pkg::seq_state_type seq_state
);
   import mbist_da_pkg::*;

   localparam int ND = N_CTRL * N_DEV;
   localparam int CW = (N_CTRL > 1) ? $clog2(N_CTRL) : 1;
   localparam int DW = (N_DEV > 1) ? $clog2(N_DEV) : 1;

   // Map a pin level to its active-high meaning.
   function automatic logic act(input logic lvl, input logic hi);
      return hi ? lvl : ~lvl;
   endfunction

   // Devices launched for one step of the schedule.
   function automatic logic [ND-1:0] launch_mask(input logic eser,
                                                 input logic dser,
                                                 input logic [CW-1:0] eng,
                                                 input logic [DW-1:0] dev);
      logic [ND-1:0] m;
      m = '0;
      for (int c = 0; c < N_CTRL; c++) begin
         for (int d = 0; d < N_DEV; d++) begin
            m[c*N_DEV+d] = (!eser || CW'(c) == eng) &&
                           (!dser || DW'(d) == dev);
         end
      end
      return m;
   endfunction

   logic [4:0] pins_s;
   logic       single_lvl;
   logic       loop_lvl;
   logic       dser_lvl;
   logic       eser_lvl;
   logic       single_ok;
   logic       loop_ok;
   logic       run_act;
   logic       step_en;

   seq_state_type   state_q;
   seq_state_type   state_d;
   run_mode_type    mode_q;
   run_mode_type    mode_d;
   logic            dser_q;
   logic            dser_d;
   logic            eser_q;
   logic            eser_d;
   logic [CW-1:0]   eng_q;
   logic [CW-1:0]   eng_d;
   logic [DW-1:0]   dev_q;
   logic [DW-1:0]   dev_d;
   logic [ND-1:0]   done_q;
   logic [ND-1:0]   done_d;
   logic [ND-1:0]   fail_q;
   logic [ND-1:0]   fail_d;
   logic [ND-1:0]   start_q;
   logic [ND-1:0]   start_d;
   logic [ND-1:0]   repair_q;
   logic [ND-1:0]   repair_d;
   logic [ND-1:0]   cur_mask;
   logic [`PASS_W-1:0] pass_q;
   logic [`PASS_W-1:0] pass_d;
   logic            tt_prev_q;
   logic            tt_prev_d;
   logic            ev_done;
   logic            ev_loop;
   logic            ev_fail;

   logic [N_CTRL-1:0] ctrl_done;
   logic [N_CTRL-1:0] ctrl_fail;
   logic              single_res;
   logic              loop_res;
   logic              mon_pin_q;
   logic              mon_pin_d;

   logic [`CTRL_W-1:0] ctrl_q;
   logic [`CTRL_W-1:0] ctrl_d;
   logic [`IRQ_W-1:0]  istat_q;
   logic [`IRQ_W-1:0]  istat_d;
   logic [`IRQ_W-1:0]  imask_q;
   logic [`IRQ_W-1:0]  imask_d;
   logic [31:0]        rdata_q;
   logic [31:0]        rdata_d;

   // All pins cross into the test clock domain before any decision.
   level_sync #(
      .W (5)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({tt_ctrl, da_eng_serial, da_dev_serial,
                  da_loop_run, da_single_run}),
      .sync_out (pins_s)
   );

   // Pins and register bits are merged, so software can run alone.
   always_comb begin
      single_lvl = act(pins_s[0], ACT_SINGLE) | ctrl_q[`CTRL_SINGLE];
      loop_lvl   = act(pins_s[1], ACT_LOOP) | ctrl_q[`CTRL_LOOP];
      dser_lvl   = act(pins_s[2], ACT_DEV_SER) | ctrl_q[`CTRL_DEV_SER];
      eser_lvl   = act(pins_s[3], ACT_ENG_SER) | ctrl_q[`CTRL_ENG_SER];
   end

   // Each run level must first sit inactive for a few clocks.
   run_qualifier #(
      .QUAL (`QUAL_INACTIVE_CYC)
   ) u_single_qual (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .level_in (single_lvl),
      .run_ok   (single_ok)
   );

   run_qualifier #(
      .QUAL (`QUAL_INACTIVE_CYC)
   ) u_loop_qual (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .level_in (loop_lvl),
      .run_ok   (loop_ok)
   );

   // With an internal oscillator the schedule only advances on each edge
   // of the test time pin, so the tester decides how long the test lasts.
   assign step_en = INTERNAL_CLK ? (pins_s[4] ^ tt_prev_q) : 1'h1;
   assign run_act = (mode_q == MODE_LOOP) ? loop_ok : single_ok;
   assign cur_mask = launch_mask(eser_q, dser_q, eng_q, dev_q);

   // Sequencer: launch, wait for the launched devices, then advance.
   always_comb begin
      state_d   = state_q;
      mode_d    = mode_q;
      dser_d    = dser_q;
      eser_d    = eser_q;
      eng_d     = eng_q;
      dev_d     = dev_q;
      start_d   = '0;
      pass_d    = pass_q;
      tt_prev_d = pins_s[4];
      ev_done   = 1'h0;
      ev_loop   = 1'h0;
      done_d    = done_q | dev_done;
      fail_d    = fail_q;
      if (state_q != ST_IDLE) begin
         fail_d = fail_q | dev_fail;
      end
      ev_fail   = |(fail_d & ~fail_q);
      repair_d  = (state_q == ST_HOLD) ? fail_q : '0;
      if (state_q != ST_IDLE && state_q != ST_HOLD && !run_act) begin
         state_d = ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (loop_ok || single_ok) begin
                  mode_d  = loop_ok ? MODE_LOOP : MODE_SINGLE;
                  dser_d  = dser_lvl;
                  eser_d  = eser_lvl;
                  eng_d   = '0;
                  dev_d   = '0;
                  done_d  = '0;
                  fail_d  = '0;
                  state_d = ST_LAUNCH;
               end
            end
            ST_LAUNCH: begin
               if (step_en) begin
                  start_d = cur_mask;
                  done_d  = (done_q & ~cur_mask) | dev_done;
                  state_d = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (&(done_q | ~cur_mask)) begin
                  state_d = ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (step_en) begin
                  state_d = ST_LAUNCH;
                  if (dser_q && dev_q != DW'(N_DEV - 1)) begin
                     dev_d = dev_q + DW'(1);
                  end else if (eser_q && eng_q != CW'(N_CTRL - 1)) begin
                     eng_d = eng_q + CW'(1);
                     dev_d = '0;
                  end else begin
                     pass_d = pass_q + `PASS_W'(1);
                     eng_d  = '0;
                     dev_d  = '0;
                     if (mode_q == MODE_LOOP) begin
                        ev_loop = 1'h1;
                     end else begin
                        ev_done = 1'h1;
                        state_d = ST_HOLD;
                     end
                  end
               end
            end
            ST_HOLD: begin
               if (!single_ok) begin
                  state_d = ST_IDLE;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // Register the sequencer.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q   <= ST_IDLE;
         mode_q    <= MODE_SINGLE;
         dser_q    <= 1'h0;
         eser_q    <= 1'h0;
         eng_q     <= '0;
         dev_q     <= '0;
         start_q   <= '0;
         done_q    <= '0;
         fail_q    <= '0;
         repair_q  <= '0;
         pass_q    <= `PASS_RST;
         tt_prev_q <= 1'h0;
      end else begin
         state_q   <= state_d;
         mode_q    <= mode_d;
         dser_q    <= dser_d;
         eser_q    <= eser_d;
         eng_q     <= eng_d;
         dev_q     <= dev_d;
         start_q   <= start_d;
         done_q    <= done_d;
         fail_q    <= fail_d;
         repair_q  <= repair_d;
         pass_q    <= pass_d;
         tt_prev_q <= tt_prev_d;
      end
   end

   // Per-controller summaries and the monitor value for each mode.
   always_comb begin
      for (int c = 0; c < N_CTRL; c++) begin
         ctrl_done[c] = &done_q[c*N_DEV +: N_DEV];
         ctrl_fail[c] = |fail_q[c*N_DEV +: N_DEV];
      end
      single_res = &(ctrl_done & ~ctrl_fail);
      loop_res   = &(~ctrl_fail);
      mon_pin_d  = act((mode_q == MODE_LOOP) ? loop_res : single_res,
                       ACT_MONITOR);
   end

   // The monitor flop drives the pin alone; no enable can hide it.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mon_pin_q <= ~ACT_MONITOR;
      end else begin
         mon_pin_q <= mon_pin_d;
      end
   end

   // Register port: writes, sticky status, read data one cycle later.
   always_comb begin
      ctrl_d  = ctrl_q;
      imask_d = imask_q;
      rdata_d = '0;
      istat_d = istat_q;
      if (reg_wr && reg_addr == `REG_CTRL) begin
         ctrl_d = reg_wdata[`CTRL_W-1:0];
      end
      if (reg_wr && reg_addr == `REG_IRQ_MASK) begin
         imask_d = reg_wdata[`IRQ_W-1:0];
      end
      if (reg_wr && reg_addr == `REG_IRQ_STAT) begin
         istat_d = istat_q & ~reg_wdata[`IRQ_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      istat_d[`IRQ_DONE] = istat_d[`IRQ_DONE] | ev_done;
      istat_d[`IRQ_FAIL] = istat_d[`IRQ_FAIL] | ev_fail;
      istat_d[`IRQ_LOOP] = istat_d[`IRQ_LOOP] | ev_loop;
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL:     rdata_d[`CTRL_W-1:0] = ctrl_q;
            `REG_STATUS: begin
               rdata_d[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_q;
               rdata_d[`STAT_MODE]   = mode_q;
               rdata_d[`STAT_RESULT] = act(mon_pin_q, ACT_MONITOR);
            end
            `REG_IRQ_STAT: rdata_d[`IRQ_W-1:0] = istat_q;
            `REG_IRQ_MASK: rdata_d[`IRQ_W-1:0] = imask_q;
            `REG_PASS_CNT: rdata_d[`PASS_W-1:0] = pass_q;
            `REG_FAIL_MAP: rdata_d[ND-1:0] = fail_q;
            default:       rdata_d = '0;
         endcase
      end
   end

   // Register the software-visible state.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q  <= `CTRL_RST;
         imask_q <= `IRQ_RST;
         istat_q <= `IRQ_RST;
         rdata_q <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         imask_q <= imask_d;
         istat_q <= istat_d;
         rdata_q <= rdata_d;
      end
   end

   assign da_monitor    = mon_pin_q;
   assign dev_start     = start_q;
   assign dev_repair_en = repair_q;
   assign reg_rdata     = rdata_q;
   assign irq           = |(istat_q & imask_q);
   assign seq_state     = state_q;

   // Helper views for the schedule checks.
   logic [N_CTRL-1:0] ctrl_started;
   logic              dev_ser_ok;
   always_comb begin
      dev_ser_ok = 1'h1;
      for (int c = 0; c < N_CTRL; c++) begin
         ctrl_started[c] = |start_q[c*N_DEV +: N_DEV];
         if ($countones(start_q[c*N_DEV +: N_DEV]) > 1) begin
            dev_ser_ok = 1'h0;
         end
      end
   end

   sequence seq_loop_dropped;
      state_q != ST_IDLE && mode_q == MODE_LOOP && !loop_ok;
   endsequence

   sequence seq_back_idle;
      state_q == ST_IDLE ##1 state_q == ST_IDLE || loop_ok;
   endsequence

   AST_LOOP_STOPS: assert property (
      @(posedge sys_clk) disable iff (rst)
      seq_loop_dropped |=> seq_back_idle)
      else $error("looped run kept going after release");

   AST_MON_SINGLE: assert property (
      @(posedge sys_clk) disable iff (rst)
      mode_q == MODE_SINGLE ##1 mode_q == MODE_SINGLE |->
      da_monitor == act($past(single_res), ACT_MONITOR))
      else $error("single-pass monitor not done and not-fail");

   AST_MON_LOOP: assert property (
      @(posedge sys_clk) disable iff (rst)
      mode_q == MODE_LOOP ##1 mode_q == MODE_LOOP |->
      da_monitor == act($past(loop_res), ACT_MONITOR))
      else $error("looped monitor not AND of not-fail");

   AST_ENG_SERIAL: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_q != '0 |-> (eser_q ? $onehot(ctrl_started) : &ctrl_started))
      else $error("controller schedule does not match select");

   AST_DEV_SERIAL: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_q != '0 |-> (dser_q ? dev_ser_ok :
                         (start_q == launch_mask(eser_q, 1'h0,
                                                 $past(eng_q), '0))))
      else $error("device schedule does not match select");

   AST_START_NEEDS_RUN: assert property (
      @(posedge sys_clk) disable iff (rst)
      start_q != '0 |-> $past(run_act) && $past(state_q) == ST_LAUNCH)
      else $error("devices started without a qualified run");

   AST_SINGLE_ONCE: assert property (
      @(posedge sys_clk) disable iff (rst)
      state_q == ST_HOLD |=> (state_q == ST_HOLD || state_q == ST_IDLE)
                             && start_q == '0)
      else $error("single pass repeated without a new run");

   AST_REPAIR_SAME_CLK: assert property (
      @(posedge sys_clk) disable iff (rst)
      dev_repair_en != '0 |-> $past(state_q) == ST_HOLD &&
                              (dev_repair_en & ~fail_q) == '0)
      else $error("repair enabled outside the hold state");

endmodule

// ==== verification/mem_dev_model.sv ====
`timescale 1ns/1ns
// Memory test devices: each answers its start pulse with a done pulse.
module mem_dev_model #(
   parameter int N = 8
) (
   // Clock and reset.
   input  logic         sys_clk,
   input  logic         rst,
   // Start pulses in, results out.
   input  logic [N-1:0] dev_start,
   input  logic [N-1:0] fail_mask,
   output logic [N-1:0] dev_done,
   output logic [N-1:0] dev_fail
);
   logic [N-1:0] s1_q;
   logic [N-1:0] s2_q;

   // Fail is a pulse beside done, so the design must hold it itself.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q     <= '0;
         s2_q     <= '0;
         dev_done <= '0;
         dev_fail <= '0;
      end else begin
         s1_q     <= dev_start;
         s2_q     <= s1_q;
         dev_done <= s2_q;
         dev_fail <= s2_q & fail_mask;
      end
   end
endmodule

// ==== verification/mbist_direct_access_ctrl_bench.sv ====
`timescale 1ns/1ns
`include "mbist_da_defines.svh"
module mbist_direct_access_ctrl_bench;
   import mbist_da_pkg::*;
   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic          da_single_run = 1'b0;
   logic          da_loop_run = 1'b0;
   logic          da_dev_serial = 1'b0;
   logic          da_eng_serial = 1'b0;
   logic          da_monitor;
   logic [7:0]    dev_start;
   logic [7:0]    dev_done;
   logic [7:0]    dev_fail;
   logic [7:0]    fmask = 8'h00;
   logic [7:0]    rep_en;
   logic          tt_ctrl = 1'b0;
   logic          tt_go = 1'b1;
   logic [7:0]    reg_addr = 8'h00;
   logic [31:0]   reg_wdata = 32'h0;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [31:0]   reg_rdata;
   logic          irq;
   seq_state_type seq_state;
   logic [31:0]   rv;
   logic [31:0]   p0;
   int            n_fail = 0;
   int            total_checks = 0;
   int            cyc = 0;

   // Active-low monitor pin, and steps paced by the test time pin.
   mbist_direct_access_ctrl #(
      .ACT_MONITOR(1'h0), .INTERNAL_CLK(1'h1)
   ) u_mbist_direct_access_ctrl (
      .sys_clk(sys_clk), .rst(rst), .da_single_run(da_single_run),
      .da_loop_run(da_loop_run), .da_dev_serial(da_dev_serial),
      .da_eng_serial(da_eng_serial), .tt_ctrl(tt_ctrl),
      .da_monitor(da_monitor), .dev_start(dev_start),
      .dev_done(dev_done), .dev_fail(dev_fail), .dev_repair_en(rep_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .seq_state(seq_state));

   mem_dev_model u_mem_dev_model (
      .sys_clk(sys_clk), .rst(rst), .dev_start(dev_start),
      .fail_mask(fmask), .dev_done(dev_done), .dev_fail(dev_fail));

   // Clock of 8 ns period; it is also the test clock, so the default
   // external test clock period is only a reference here.
   always #4 sys_clk = ~sys_clk;

   // The tester toggles the test time pin; each edge allows one step.
   always @(posedge sys_clk) begin
      if (tt_go) tt_ctrl <= ~tt_ctrl;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hung sequencer must not stall the run forever.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask

   task automatic wait_st(input seq_state_type s);
      for (int i = 0; i < 400 && seq_state !== s; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk({27'h0, seq_state}, {27'h0, s});
   endtask

   // One single pass; selects stay steady until the pass is over.
   task automatic run1(input logic ds, input logic es, input logic ureg,
                       input logic [7:0] st, input logic mon,
                       input logic [7:0] rep);
      @(posedge sys_clk);
      da_dev_serial <= ds;
      da_eng_serial <= es;
      repeat (5) @(posedge sys_clk);
      if (ureg) wr(`REG_CTRL, 32'h1);
      else da_single_run <= 1'b1;
      for (int i = 0; i < 40 && dev_start === 8'h00; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk({24'h0, dev_start}, {24'h0, st});
      wait_st(ST_HOLD);
      chk({31'h0, da_monitor}, {31'h0, ~mon});
      // Repair enables follow the failed devices one clock into the hold.
      @(posedge sys_clk);
      #1;
      chk({24'h0, rep_en}, {24'h0, rep});
      if (ureg) wr(`REG_CTRL, 32'h0);
      else da_single_run <= 1'b0;
      wait_st(ST_IDLE);
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk({31'h0, da_monitor}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wait_st(ST_IDLE);
      // Every schedule combination in turn, first start pattern known.
      run1(1'b0, 1'b0, 1'b0, 8'hff, 1'b1, 8'h00);
      run1(1'b1, 1'b0, 1'b0, 8'h11, 1'b1, 8'h00);
      run1(1'b0, 1'b1, 1'b0, 8'h0f, 1'b1, 8'h00);
      run1(1'b1, 1'b1, 1'b0, 8'h01, 1'b1, 8'h00);
      rd(`REG_PASS_CNT);
      chk(rv, 32'h4);
      rd(`REG_IRQ_STAT);
      chk(rv & 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`REG_IRQ_MASK, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h1);
      wr(`REG_IRQ_STAT, 32'h7);
      #1;
      chk({31'h0, irq}, 32'h0);
      rd(8'h3c);
      chk(rv, 32'h0);
      // Test time pin paused: the run must wait in the launch state.
      @(posedge sys_clk);
      tt_go         <= 1'b0;
      da_single_run <= 1'b1;
      repeat (20) @(posedge sys_clk);
      #1;
      chk({27'h0, seq_state}, {27'h0, ST_LAUNCH});
      tt_go <= 1'b1;
      wait_st(ST_HOLD);
      chk({31'h0, irq}, 32'h1);
      da_single_run <= 1'b0;
      wait_st(ST_IDLE);
      // A failing device drives the monitor high, its inactive level.
      fmask <= 8'h24;
      run1(1'b0, 1'b0, 1'b0, 8'hff, 1'b0, 8'h24);
      rd(`REG_FAIL_MAP);
      chk(rv, 32'h24);
      // Register control alone, fail map cleared at start.
      fmask <= 8'h00;
      run1(1'b0, 1'b0, 1'b1, 8'hff, 1'b1, 8'h00);
      rd(`REG_PASS_CNT);
      p0 = rv;
      // Looped run: passes repeat, monitor ignores done.
      da_loop_run <= 1'b1;
      repeat (120) @(posedge sys_clk);
      wait_st(ST_WAIT);
      // The done bits clear on entry to the wait state, so one clock later only the loop
      // formula still shows a good result.
      @(posedge sys_clk);
      #1;
      chk({31'h0, da_monitor}, 32'h0);
      rd(`REG_PASS_CNT);
      chk({31'h0, rv > p0 + 1}, 32'h1);
      rd(`REG_IRQ_STAT);
      chk(rv & 32'h4, 32'h4);
      fmask <= 8'h80;
      repeat (60) @(posedge sys_clk);
      #1;
      chk({31'h0, da_monitor}, 32'h1);
      da_loop_run <= 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      chk({27'h0, seq_state}, {27'h0, ST_IDLE});
      // Idle, loop mode kept, failing result shown active high.
      rd(`REG_STATUS);
      chk(rv, 32'h21);
      print_verdict;
   end
endmodule
